// *** hdl/flash_host.sv ***
// host controller that issues flash command sequences and polls status
//
// What this block does
// - chip erase sends unlock, unlock, 80H, unlock, unlock, 10H
// - sector erase sends unlock, unlock, 80H, unlock, unlock, 30H at SA
// - extra sector loads must start within 80ms of previous rising edge
// - program sends unlock, unlock, A0H, then address and data
// - unlock uses 555H/AAH then 2AAH/55H on the low eleven lines
//
// The AHB-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output flash_host_pkg::flash_pins_s pins,
    output logic      [7:0]  dq_out,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_in
);
    typedef enum logic [2:0] {
        s_idle  = 3'b000,
        s_setup = 3'b001,
        s_pulse = 3'b011,
        s_hold  = 3'b010,
        s_rsamp = 3'b110,
        s_rend  = 3'b111,
        s_check = 3'b101
    } state_e;

    state_e                     state;
    flash_host_pkg::op_e        op;
    flash_host_pkg::host_status_s st;
    logic [2:0]  step;
    logic [2:0]  nsteps;
    logic [3:0]  tcnt;
    logic [31:0] win_cnt;
    logic [20:0] tgt_addr;
    logic [7:0]  tgt_data;
    logic        suspended;
    logic        erasing;
    logic        polling;
    logic        have_prev;
    logic [7:0]  prev_rd;
    logic [7:0]  dq_s1;
    logic [7:0]  dq_s2;
    logic        wr_pend;
    logic [7:0]  wr_off;
    flash_host_pkg::op_e        cmd_op;
    logic        cmd_pend;
    logic        take;
    logic [20:0] cyc_addr;
    logic [7:0]  cyc_data;
    logic        go;

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_off  <= 8'h00;
        end else begin
            wr_pend <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready)
                wr_off <= haddr[7:0];
        end
    end

    // a control write waits here until the sequencer is back in idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_pend <= 1'b0;
            cmd_op   <= flash_host_pkg::op_none;
        end else if (wr_pend && wr_off == `REG_CTRL) begin
            cmd_pend <= 1'b1;
            cmd_op   <= flash_host_pkg::op_e'(hwdata[2:0]);
        end else if (state == s_idle) begin
            cmd_pend <= 1'b0;
        end
    end

    // orders that the flash accepts in its present mode
    always_comb begin
        unique case (cmd_op)
            flash_host_pkg::op_program,
            flash_host_pkg::op_read:    take = !polling;
            flash_host_pkg::op_chip,
            flash_host_pkg::op_sector:
                take = !polling && !suspended;
            flash_host_pkg::op_more:
                take = st.window_open && win_cnt != 32'h0000_0000;
            flash_host_pkg::op_suspend:
                take = erasing && polling
                       && op != flash_host_pkg::op_chip;
            flash_host_pkg::op_resume:  take = suspended;
            default:                    take = 1'b0;
        endcase
    end

    assign go = cmd_pend && take && state == s_idle;

    // read data mux, single cycle, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            unique case (haddr[7:0])
                `REG_ADDR:   hrdata <= {11'h000, tgt_addr};
                `REG_DATA:   hrdata <= {24'h00_0000, tgt_data};
                `REG_STATUS: hrdata <= {26'h000_0000, suspended,
                                        st.window_open, st.fail, st.done,
                                        st.busy, erasing};
                `REG_RDATA:  hrdata <= {24'h00_0000, st.last_read};
                default:     hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tgt_addr <= 21'h00_0000;
            tgt_data <= 8'h00;
        end else if (wr_pend && state == s_idle && !polling) begin
            if (wr_off == `REG_ADDR) tgt_addr <= hwdata[20:0];
            if (wr_off == `REG_DATA) tgt_data <= hwdata[7:0];
        end
    end

    // two-flop input synchroniser for the data bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // address/data for each write step of the current operation
    always_comb begin
        cyc_addr = {10'h000, `UNLOCK_A1};
        cyc_data = `UNLOCK_D1;
        unique case (op)
            flash_host_pkg::op_more: begin
                cyc_addr = tgt_addr;
                cyc_data = `CMD_SECT_ERASE;
            end
            flash_host_pkg::op_suspend: cyc_data = `CMD_SUSPEND;
            flash_host_pkg::op_resume:  cyc_data = `CMD_RESUME;
            default: begin
                unique case (step)
                    3'd1, 3'd4: begin
                        cyc_addr = {10'h000, `UNLOCK_A2};
                        cyc_data = `UNLOCK_D2;
                    end
                    3'd2: cyc_data = (op == flash_host_pkg::op_program) ?
                                     `CMD_PROGRAM : `CMD_SETUP;
                    3'd3: cyc_addr = (op == flash_host_pkg::op_program) ?
                                     tgt_addr : {10'h000, `UNLOCK_A1};
                    3'd5: begin
                        if (op == flash_host_pkg::op_chip) begin
                            cyc_data = `CMD_CHIP_ERASE;
                        end else begin
                            cyc_addr = tgt_addr;
                            cyc_data = `CMD_SECT_ERASE;
                        end
                    end
                    default: ;
                endcase
                if (op == flash_host_pkg::op_program && step == 3'd3)
                    cyc_data = tgt_data;
            end
        endcase
    end

    // sequencer: write strobes, then read polling
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= s_idle;
            op        <= flash_host_pkg::op_none;
            step      <= 3'd0;
            nsteps    <= 3'd0;
            tcnt      <= 4'h0;
            pins      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h0};
            dq_out    <= 8'h00;
            dq_oe     <= 1'b0;
            polling   <= 1'b0;
            have_prev <= 1'b0;
            prev_rd   <= 8'h00;
            st        <= '0;
            suspended <= 1'b0;
            erasing   <= 1'b0;
        end else begin
            unique case (state)
                s_idle: begin
                    if (go) begin
                        op        <= cmd_op;
                        step      <= 3'd0;
                        have_prev <= 1'b0;
                        st.done   <= 1'b0;
                        st.fail   <= 1'b0;
                        st.busy   <= 1'b1;
                        tcnt      <= 4'h0;
                        unique case (cmd_op)
                            flash_host_pkg::op_program: begin
                                nsteps <= 3'd3;
                                state  <= s_setup;
                            end
                            flash_host_pkg::op_chip,
                            flash_host_pkg::op_sector: begin
                                nsteps <= 3'd5;
                                state  <= s_setup;
                            end
                            flash_host_pkg::op_read: begin
                                state <= s_rsamp;
                                pins  <= '{ce_n: 1'b0, oe_n: 1'b0,
                                           we_n: 1'b1, addr: tgt_addr};
                            end
                            default: begin
                                nsteps <= 3'd0;
                                state  <= s_setup;
                            end
                        endcase
                    end else if (st.busy && polling) begin
                        state <= s_rsamp;
                        pins  <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1,
                                   addr: tgt_addr};
                        tcnt  <= 4'h0;
                    end
                end
                s_setup: begin
                    pins   <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0,
                                addr: cyc_addr};
                    dq_out <= cyc_data;
                    dq_oe  <= 1'b1;
                    tcnt   <= 4'h0;
                    state  <= s_pulse;
                end
                s_pulse: begin
                    tcnt <= tcnt + 4'h1;
                    if (tcnt == 4'(`STROBE_CYC - 1)) begin
                        pins.we_n <= 1'b1;
                        state     <= s_hold;
                    end
                end
                s_hold: begin
                    pins.ce_n <= 1'b1;
                    dq_oe     <= 1'b0;
                    if (step == nsteps) begin
                        state <= s_idle;
                        unique case (op)
                            flash_host_pkg::op_suspend: begin
                                suspended      <= 1'b1;
                                st.window_open <= 1'b0;
                                st.busy        <= 1'b0;
                                polling        <= 1'b0;
                            end
                            flash_host_pkg::op_resume: begin
                                suspended <= 1'b0;
                                polling   <= 1'b1;
                            end
                            flash_host_pkg::op_sector,
                            flash_host_pkg::op_more: begin
                                erasing        <= 1'b1;
                                st.window_open <= 1'b1;
                                st.busy        <= 1'b1;
                                polling        <= 1'b1;
                            end
                            flash_host_pkg::op_chip: begin
                                erasing <= 1'b1; polling <= 1'b1;
                            end
                            default: polling <= 1'b1;
                        endcase
                    end else begin
                        step  <= step + 3'd1;
                        state <= s_setup;
                    end
                end
                s_rsamp: begin
                    tcnt <= tcnt + 4'h1;
                    if (tcnt == 4'(`STROBE_CYC + 1)) begin
                        st.last_read <= dq_s2;
                        pins.oe_n    <= 1'b1;
                        pins.ce_n    <= 1'b1;
                        state        <= polling ? s_check : s_rend;
                    end
                end
                s_rend: begin
                    st.busy <= 1'b0;
                    state   <= s_idle;
                end
                s_check: begin
                    state     <= s_idle;
                    have_prev <= 1'b1;
                    prev_rd   <= st.last_read;
                    if (have_prev && st.last_read[`BIT_TOGGLE]
                                 == prev_rd[`BIT_TOGGLE]) begin
                        if (op == flash_host_pkg::op_program) begin
                            if (st.last_read[7:6] == tgt_data[7:6])
                                st.done <= 1'b1;
                            else
                                st.fail <= 1'b1;
                        end else if (st.last_read[`BIT_POLL]) begin
                            st.done <= 1'b1; erasing <= 1'b0;
                        end else begin
                            st.fail <= 1'b1;
                        end
                        st.busy <= 1'b0; polling <= 1'b0;
                        st.window_open <= 1'b0;
                    end else if (have_prev
                                 && st.last_read[`BIT_TIMEOUT]
                                 && prev_rd[`BIT_TIMEOUT]) begin
                        st.fail <= 1'b1; st.busy <= 1'b0;
                        polling <= 1'b0; erasing <= 1'b0;
                        st.window_open <= 1'b0;
                    end else if (st.last_read[`BIT_WINDOW]) begin
                        st.window_open <= 1'b0;
                    end
                end
                default: state <= s_idle;
            endcase
        end
    end

    // load window timer from last rising edge of the write strobe
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            win_cnt <= 32'h0000_0000;
        else if (state == s_hold)
            win_cnt <= 32'(`LOAD_WINDOW_CYC);
        else if (win_cnt != 32'h0000_0000)
            win_cnt <= win_cnt - 32'h0000_0001;
    end
endmodule // flash_host

// *** inc/flash_host_defs.svh ***
// register map, command codes and timing counts of the flash host controller
`ifndef FLASH_HOST_DEFS_SVH
`define FLASH_HOST_DEFS_SVH
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_DATA        8'h08
`define REG_STATUS      8'h0C
`define REG_RDATA       8'h10
`define UNLOCK_A1       11'h555
`define UNLOCK_A2       11'h2AA
`define UNLOCK_D1       8'hAA
`define UNLOCK_D2       8'h55
`define CMD_SETUP       8'h80
`define CMD_CHIP_ERASE  8'h10
`define CMD_SECT_ERASE  8'h30
`define CMD_PROGRAM     8'hA0
`define CMD_SUSPEND     8'hB0
`define CMD_RESUME      8'h30
`define CLK_PERIOD_NS   100
`define STROBE_NS       200
`define STROBE_CYC      (((`STROBE_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define LOAD_WINDOW_MS  80
`define LOAD_WINDOW_CYC ((`LOAD_WINDOW_MS) * 1000000 / (`CLK_PERIOD_NS))
`define BIT_POLL        7
`define BIT_TOGGLE      6
`define BIT_TIMEOUT     5
`define BIT_WINDOW      3
`define BIT_SECT_TOGGLE 2
`endif

// *** inc/flash_host_pkg.sv ***
// types shared by the flash host controller
package flash_host_pkg;
    typedef enum logic [2:0] {
        op_none    = 3'd0,
        op_program = 3'd1,
        op_chip    = 3'd2,
        op_sector  = 3'd3,
        op_more    = 3'd4,
        op_suspend = 3'd5,
        op_resume  = 3'd6,
        op_read    = 3'd7
    } op_e;
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [20:0] addr;
    } flash_pins_s;
    typedef struct packed {
        logic       busy;
        logic       done;
        logic       fail;
        logic       window_open;
        logic [7:0] last_read;
    } host_status_s;
endpackage

// *** testbench/flash_host_props.sv ***
// concurrent checks on the flash strobes and bus answers of the host
`timescale 1ns/1ps
module flash_host_props (
    input wire logic                        hclk,
    input wire logic                        hresetn,
    input wire logic                        hreadyout,
    input wire logic                        hresp,
    input wire flash_host_pkg::flash_pins_s pins,
    input wire logic [7:0]                  dq_out,
    input wire logic                        dq_oe
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence wr_pulse;
        !pins.we_n [*2] ##1 pins.we_n;
    endsequence
    sequence rd_pulse;
        !pins.oe_n [*4];
    endsequence
    a_we_pulse_len: assert property ($fell(pins.we_n) |-> wr_pulse)
        else $error("write strobe not two cycles low");
    a_release_after_wr: assert property (
        $rose(pins.we_n) |=> pins.ce_n && !dq_oe)
        else $error("bus not released after write");
    a_wr_hold: assert property (
        $fell(pins.we_n) |=> $stable(pins.addr) && $stable(dq_out))
        else $error("address or data moved in write strobe");
    a_data_at_rise: assert property (
        $rose(pins.we_n) |-> dq_oe && $stable(dq_out))
        else $error("data not held at write strobe rise");
    a_we_frame: assert property (
        !pins.we_n |-> !pins.ce_n && pins.oe_n && dq_oe)
        else $error("write strobe outside a write frame");
    a_oe_excl: assert property (
        !pins.oe_n |-> pins.we_n && !dq_oe && !pins.ce_n)
        else $error("read strobe with bus driven");
    a_read_len: assert property ($fell(pins.oe_n) |-> rd_pulse)
        else $error("read strobe shorter than four cycles");
    a_okay_resp: assert property (hresp == 1'b0 && hreadyout == 1'b1)
        else $error("bus answer not zero wait okay");
endmodule // flash_host_props
bind flash_host flash_host_props u_props (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe)
);

// *** testbench/flash_dev_model.sv ***
// behavioural model of the parallel flash device behind the host
`timescale 1ns/1ps
module flash_dev_model #(
    parameter int WIN_NS      = 30000,
    parameter int ERASE_READS = 8,
    parameter int PROG_READS  = 4
) (
    input  wire flash_host_pkg::flash_pins_s pins,
    input  wire logic [7:0]                  dq_out,
    input  wire logic                        dq_oe,
    input  wire logic                        stall,
    output logic [7:0]                       dq_in
);
    logic [7:0]  mem [int];
    logic [7:0]  d, pd;
    logic [20:0] a_lat, pa;
    logic [31:0] sect = '0;
    logic        prog_on = 0, erase_on = 0, win = 0, susp = 0, chip = 0;
    logic        tog = 0, stog = 0, ins = 0;
    int          st = 0, left = 0, nw = 0, ks[$];
    realtime     t_rise;
    wire [10:0]  u = a_lat[10:0];
    initial dq_in = 8'h00;
    always @(negedge pins.we_n) if (!pins.ce_n) a_lat = pins.addr;
    always @(posedge pins.we_n) if (!pins.ce_n) begin
        d = dq_out;
        nw++;
        if (prog_on) st = 0;
        else if (erase_on) begin
            if (d == 8'hB0 && !chip) {erase_on, susp} = 2'b01;
        end else if (win) begin
            if (d == 8'h30) t_rise = $realtime;
            if (d == 8'h30) sect[a_lat[20:16]] = 1'b1;
            else if (d == 8'hB0) {win, susp} = 2'b01;
            else {win, sect} = '0;
        end else if (susp && st == 0 && d == 8'h30) begin
            {susp, erase_on} = 2'b01;
        end else case (st)
            0: st = (u == 11'h555 && d == 8'hAA) ? 1 : 0;
            1: st = (u == 11'h2AA && d == 8'h55) ? 2 : 0;
            2: st = u != 11'h555 ? 0 : d == 8'hA0 ? 3 :
                    (d == 8'h80 && !susp) ? 4 : 0;
            3: begin
                {pa, pd, prog_on, st} = {a_lat, d, 1'b1, 32'h0000_0000};
                left = PROG_READS;
            end
            4: st = (u == 11'h555 && d == 8'hAA) ? 5 : 0;
            5: st = (u == 11'h2AA && d == 8'h55) ? 6 : 0;
            default: begin
                st = 0;
                left = ERASE_READS;
                chip = d == 8'h10 && u == 11'h555;
                erase_on = chip;
                win = d == 8'h30;
                sect = win ? 32'h0000_0001 << a_lat[20:16] : '0;
                t_rise = $realtime;
            end
        endcase
    end
    always @(negedge pins.oe_n) begin
        if (win && $realtime - t_rise > WIN_NS) {win, erase_on} = 2'b01;
        ins = sect[pins.addr[20:16]] || chip;
        if (prog_on) dq_in = {~pd[7], tog, stall, 5'b00100};
        else if (erase_on) dq_in = {1'b0, tog, stall, 2'b01, stog, 2'b00};
        else if (win) dq_in = {1'b0, tog, 3'b000, stog, 2'b00};
        else if (susp && ins) dq_in = {5'b11000, stog, 2'b00};
        else dq_in = mem.exists(pins.addr) ? mem[pins.addr] : 8'hFF;
    end
    always @(posedge pins.oe_n) begin
        dq_in = ~dq_in;
        tog = tog ^ (prog_on || erase_on || win);
        stog = stog ^ (erase_on || win || (susp && ins));
        if (prog_on && !stall && --left <= 0) begin
            mem[pa] = (mem.exists(pa) ? mem[pa] : 8'hFF) & pd;
            prog_on = 0;
        end
        if (erase_on && !stall && --left <= 0) begin
            foreach (mem[k]) if (chip || sect[k[20:16]]) ks.push_back(k);
            foreach (ks[i]) mem.delete(ks[i]);
            {erase_on, chip, sect} = '0;
            ks.delete();
        end
    end
endmodule // flash_dev_model

// *** testbench/flash_host_tb.sv ***
// self-checking testbench of the flash host controller
`timescale 1ns/1ps
`include "flash_host_defs.svh"
module flash_host_tb;
    logic        hclk, hresetn, hsel, hwrite, hready, stall, hreadyout;
    logic        hresp, dq_oe;
    logic [31:0] haddr, hwdata, hrdata, st, rv;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  dq_out, dq_in;
    int          errors, n_tests, nw;
    flash_host_pkg::flash_pins_s pins;
    assign hready = hreadyout;
    flash_host dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pins(pins),
        .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    flash_dev_model dev (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
        .stall(stall), .dq_in(dq_in));
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'b10;
        haddr <= {24'h0000_00, a};
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic op(input logic [2:0] c, input logic [20:0] a,
                      input logic [7:0] d, input bit w);
        ahb(1'b1, `REG_ADDR, {11'h000, a}, rv);
        ahb(1'b1, `REG_DATA, {24'h0000_00, d}, rv);
        ahb(1'b1, `REG_CTRL, {29'h0000_0000, c}, rv);
        repeat (2) @(posedge hclk);
        st = 32'h0000_0002;
        for (int i = 0; i < 3000 && w && st[1] !== 1'b0; i++)
            ahb(1'b0, `REG_STATUS, '0, st);
        if (w) chk(st[1], 1'b0);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic rdf(input logic [20:0] a, input logic [7:0] e,
                       input logic [7:0] m);
        op(3'd7, a, 8'h00, 1'b1);
        ahb(1'b0, `REG_RDATA, '0, rv);
        chk(rv & {24'h0000_00, m}, {24'h0000_00, e});
    endtask
    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge hclk);
        errors++;
        close_out;
    end
    initial begin
        {hresetn, hsel, hwrite, stall, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, `REG_STATUS, '0, st);
        chk(st, '0);
        ahb(1'b0, 8'h20, '0, rv);
        chk(rv, '0);
        $display("reset and map test done");
        op(3'd1, 21'h01_2345, 8'h5A, 1'b1);
        chk(st[3:2], 2'b01);
        rdf(21'h01_2345, 8'h5A, 8'hFF);
        op(3'd1, 21'h02_0000, 8'h12, 1'b1);
        rdf(21'h02_0000, 8'h12, 8'hFF);
        $display("program test done");
        op(3'd3, 21'h01_0000, 8'h00, 1'b1);
        chk(st[3:2], 2'b01);
        rdf(21'h01_2345, 8'hFF, 8'hFF);
        rdf(21'h02_0000, 8'h12, 8'hFF);
        op(3'd2, '0, 8'h00, 1'b1);
        rdf(21'h02_0000, 8'hFF, 8'hFF);
        $display("erase test done");
        op(3'd1, 21'h03_0004, 8'h81, 1'b1);
        op(3'd3, 21'h03_0000, 8'h00, 1'b0);
        repeat (80) @(posedge hclk);
        ahb(1'b0, `REG_STATUS, '0, st);
        chk(st, 32'h0000_0013);
        op(3'd5, '0, 8'h00, 1'b1);
        chk(st, 32'h0000_0021);
        chk(dev.susp, 1'b1);
        rdf(21'h03_0004, 8'hC0, 8'hE8);
        op(3'd6, '0, 8'h00, 1'b1);
        chk(dev.susp, 1'b0);
        rdf(21'h03_0004, 8'hFF, 8'hFF);
        nw = dev.nw;
        op(3'd6, '0, 8'h00, 1'b1);
        chk(dev.nw, nw);
        $display("suspend test done");
        stall <= 1'b1;
        op(3'd1, 21'h00_0020, 8'h11, 1'b1);
        chk(st[3:2], 2'b10);
        $display("timeout test done");
        close_out;
    end
endmodule // flash_host_tb
